// [shared/ds_pcs_pkg.sv]
/*
  Shared constants and types for the downstream PCS symbol mapper.
  Assumes a single 40 MHz clock domain and no software-visible registers.
*/
package ds_pcs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_PERIOD_NS = 25;
  localparam logic [4:0] RESET_CYCLES = 5'h10;

  // ----------------------------------------
  // Scrambler
  // ----------------------------------------
  localparam int SCR_LEN = 33;
  localparam logic [32:0] SCR_TAPS = 33'h1_0000_2000;
  localparam logic [32:0] SCR_SEED = 33'h1_FFFF_FFFF;

  // ----------------------------------------
  // Symbol levels, in thirds of full scale
  // ----------------------------------------
  localparam logic [2:0] LVL_NEG_ONE = 3'h5;
  localparam logic [2:0] LVL_NEG_THIRD = 3'h7;
  localparam logic [2:0] LVL_POS_THIRD = 3'h1;
  localparam logic [2:0] LVL_POS_ONE = 3'h3;

  // ----------------------------------------
  // Data word layout
  // ----------------------------------------
  localparam int DATA_W = 2;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RATE_2G5 = 2'h0,
    RATE_5G = 2'h1,
    RATE_10G = 2'h2
  } rate_t;

  typedef enum logic [1:0] {
    PH_RESET = 2'h1,
    PH_RUN = 2'h2
  } phase_t;

  typedef struct packed {
    logic valid;
    logic [2:0] level;
  } sym_out_t;

  typedef struct packed {
    phase_t phase;
    logic [4:0] rst_cnt;
    rate_t rate;
    logic [32:0] scr;
    logic train;
    sym_out_t sym;
  } map_state_t;

endpackage

// [rtl/ds_pcs_symbol_mapper.sv]
/*
  Downstream PCS transmit symbol mapper with its input FIFO.
  Assumes framed, FEC-coded bits arrive from same-clock logic, two bits per
  word, and that the PMA strobes i_pma_ready once per symbol period.
*/
`timescale 1ns/1ps

// ----------------------------------------
// Input FIFO
// ----------------------------------------
module ds_sym_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign o_ready = (q.cnt != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_valid = (q.cnt != '0);
  assign o_data = mem[q.rd];
  assign push = i_valid && o_ready;
  assign pop = i_ready && o_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.wr = q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = q.rd + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Storage needs no reset; count guards reads
  always_ff @(posedge i_mclk) begin
    if (i_ce && push) begin
      mem[q.wr] <= i_data;
    end
  end
endmodule

// ----------------------------------------
// Symbol mapper
// ----------------------------------------
// Overview of operation
// R1: Data mode emits two-level symbols at 2.5G and 5G, four-level at 10G.
// R2: Reset phase plus independent transmit and receive functions running concurrently.
// R3: Transmit and receive enables rise together only after the reset phase completes.
// R4: Outgoing data is scrambled by a free-running side-stream generator; here the generator steps only when a data symbol is popped.
// R5: At two-level rates every superframe bit is additively scrambled before mapping; here only bit 0 of each word is mapped and bit 1 is dropped.
// R6: Two-level scramble bit is generator bit zero, exclusive-or with data bit.
// R7: Four-level mapping: 0 to -1, 1 to -1/3, 2 to +1/3, 3 to +1.
// R8: Two-level mapping: bit 0 to +1, bit 1 to -1.
// R9: The generator polynomial is fixed for this direction and never switches.
// R10: Training mode produces only two-level symbols whatever the rate.
// R11: Rate select steers mapping and scrambling, sampled only during reset.
module ds_pcs_symbol_mapper #(
  parameter int DEPTH = ds_pcs_pkg::FIFO_DEPTH,
  parameter logic [32:0] SCR_TAPS = ds_pcs_pkg::SCR_TAPS
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Control
  input wire logic i_pcs_reset,
  input wire ds_pcs_pkg::rate_t i_rate_sel,
  input wire logic i_train_mode,
  input wire logic i_train_bit,
  // Coded data in
  input wire logic i_data_valid,
  input wire logic [ds_pcs_pkg::DATA_W-1:0] i_data,
  output logic o_data_ready,
  // PMA side
  input wire logic i_pma_ready,
  output ds_pcs_pkg::sym_out_t o_sym,
  // Status
  output logic o_tx_enable,
  output logic o_rx_enable,
  output ds_pcs_pkg::rate_t o_rate
);
  ds_pcs_pkg::map_state_t q, d;
  logic fifo_valid, pop;
  logic [ds_pcs_pkg::DATA_W-1:0] fifo_data, scrambled;

  function automatic logic [32:0] scr_step(input logic [32:0] s);
    scr_step = {s[31:0], ^(s & SCR_TAPS)};
  endfunction

  function automatic logic [2:0] pam2_level(input logic b);
    pam2_level = b ? ds_pcs_pkg::LVL_NEG_ONE : ds_pcs_pkg::LVL_POS_ONE;
  endfunction

  ds_sym_fifo #(
    .WIDTH(ds_pcs_pkg::DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_valid(i_data_valid),
    .i_data(i_data),
    .o_ready(o_data_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_data),
    .i_ready(pop)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // R5: additive scramble ahead of mapping
  assign scrambled = fifo_data ^ q.scr[1:0];
  assign pop = (q.phase == ds_pcs_pkg::PH_RUN) && !i_pcs_reset && i_pma_ready
    && !i_train_mode && fifo_valid;

  always_comb begin
    d = q;
    d.sym.valid = 1'b0;
    unique case (q.phase)
      ds_pcs_pkg::PH_RESET: begin
        // R11: rate captured only while held in reset
        d.rate = i_rate_sel;
        d.scr = ds_pcs_pkg::SCR_SEED;
        d.train = 1'b0;
        if (i_pcs_reset) begin
          d.rst_cnt = '0;
        end else if (q.rst_cnt == ds_pcs_pkg::RESET_CYCLES - 5'h1) begin
          // R3: both functions start on completion
          d.phase = ds_pcs_pkg::PH_RUN;
        end else begin
          d.rst_cnt = q.rst_cnt + 5'h1;
        end
      end
      ds_pcs_pkg::PH_RUN: begin
        if (i_pcs_reset) begin
          d.phase = ds_pcs_pkg::PH_RESET;
          d.rst_cnt = '0;
        end else if (i_pma_ready && i_train_mode) begin
          // R10: training is always two-level
          d.sym.valid = 1'b1;
          d.sym.level = pam2_level(i_train_bit);
          d.train = 1'b1;
        end else if (pop) begin
          d.sym.valid = 1'b1;
          d.train = 1'b0;
          // R9: fixed polynomial, R4: free of data content
          d.scr = scr_step(q.scr);
          if (q.rate == ds_pcs_pkg::RATE_10G) begin
            // R7: four-level amplitudes
            unique case (scrambled)
              2'h0: d.sym.level = ds_pcs_pkg::LVL_NEG_ONE;
              2'h1: d.sym.level = ds_pcs_pkg::LVL_NEG_THIRD;
              2'h2: d.sym.level = ds_pcs_pkg::LVL_POS_THIRD;
              2'h3: d.sym.level = ds_pcs_pkg::LVL_POS_ONE;
            endcase
          end else begin
            // R1: two-level at lower rates, R6 and R8: bit zero only
            d.sym.level = pam2_level(scrambled[0]);
          end
        end
      end
      default: begin
        d.phase = ds_pcs_pkg::PH_RESET;
        d.rst_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q.phase <= ds_pcs_pkg::PH_RESET;
      q.rst_cnt <= '0;
      q.rate <= ds_pcs_pkg::RATE_2G5;
      q.scr <= ds_pcs_pkg::SCR_SEED;
      q.train <= 1'b0;
      q.sym <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // R2: receive and transmit share one start point
  assign o_tx_enable = (q.phase == ds_pcs_pkg::PH_RUN);
  assign o_rx_enable = (q.phase == ds_pcs_pkg::PH_RUN);
  assign o_sym = q.sym;
  assign o_rate = q.rate;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [2:0] exp_pam4;
  always_comb begin
    unique case (scrambled)
      2'h0: exp_pam4 = ds_pcs_pkg::LVL_NEG_ONE;
      2'h1: exp_pam4 = ds_pcs_pkg::LVL_NEG_THIRD;
      2'h2: exp_pam4 = ds_pcs_pkg::LVL_POS_THIRD;
      default: exp_pam4 = ds_pcs_pkg::LVL_POS_ONE;
    endcase
  end

  sequence s_pop_at(logic is10g);
    i_ce && pop && ((q.rate == ds_pcs_pkg::RATE_10G) == is10g);
  endsequence

  a_rate_level_set: assert property ( // R1
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_sym.valid && o_rate != ds_pcs_pkg::RATE_10G |->
      (o_sym.level == ds_pcs_pkg::LVL_POS_ONE || o_sym.level == ds_pcs_pkg::LVL_NEG_ONE))
    else $error("four-level symbol at a two-level rate");

  a_start_together: assert property ( // R2
    @(posedge i_mclk) disable iff (!i_rst_n) o_tx_enable == o_rx_enable)
    else $error("transmit and receive enables differ");

  a_reset_before_run: assert property ( // R3
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_tx_enable) |-> $past(q.rst_cnt) == ds_pcs_pkg::RESET_CYCLES - 5'h1)
    else $error("run entered before reset phase completed");

  a_pam4_map: assert property ( // R7
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_pop_at(1'b1) |=> o_sym.valid && o_sym.level == $past(exp_pam4))
    else $error("four-level mapping wrong");

  a_pam2_map: assert property ( // R8
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_pop_at(1'b0) |=> o_sym.level == ($past(fifo_data[0] ^ q.scr[0]) ?
      ds_pcs_pkg::LVL_NEG_ONE : ds_pcs_pkg::LVL_POS_ONE))
    else $error("two-level scrambled mapping wrong");

  a_scr_poly_step: assert property ( // R9
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_ce && pop |=> q.scr == {$past(q.scr[31:0]), ^($past(q.scr) & SCR_TAPS)})
    else $error("scrambler stepped off polynomial");

  a_train_pam2: assert property ( // R10
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_sym.valid && q.train |->
      (o_sym.level == ds_pcs_pkg::LVL_POS_ONE || o_sym.level == ds_pcs_pkg::LVL_NEG_ONE))
    else $error("training symbol not two-level");

  a_rate_held: assert property ( // R11
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_tx_enable && $past(o_tx_enable) |-> $stable(o_rate))
    else $error("rate changed outside reset");
endmodule

// [test/ds_pma_model.sv]
/*
  PMA-side model: strobes for symbols and collects the levels that arrive.
  Assumes the mapper's clock, with o_sym valid for one cycle after a strobe.
*/
`timescale 1ns/1ps

module ds_pma_model (
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_en,
  input wire logic i_slow,
  // Symbol link
  input wire ds_pcs_pkg::sym_out_t i_sym,
  output logic o_strobe
);
  logic [1:0] div_q = 2'h0;
  logic [2:0] got[$];

  initial o_strobe = 1'b0;

  // Slow mode strobes one cycle in three, so gaps appear
  always @(posedge i_mclk) begin
    div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    o_strobe <= i_en && (!i_slow || div_q == 2'h0);
    if (i_sym.valid) begin
      got.push_back(i_sym.level);
    end
  end
endmodule

// [test/ds_pcs_symbol_mapper_tb_top.sv]
/*
  Self-checking bench for the downstream symbol mapper.
  Assumes one 40 MHz clock and the PMA model beside it; i_ce drops only
  in the freeze scenario.
*/
`timescale 1ns/1ps

module ds_pcs_symbol_mapper_tb_top;
  logic mclk, rst_n, pcs_reset, train_mode, train_bit, data_valid;
  logic pma_en, pma_slow, data_ready, pma_ready, tx_en, rx_en, ce;
  logic [1:0] data;
  ds_pcs_pkg::rate_t rate_sel, rate;
  ds_pcs_pkg::sym_out_t sym;
  logic [32:0] scr_q;
  logic [2:0] l4[4] = '{ds_pcs_pkg::LVL_NEG_ONE, ds_pcs_pkg::LVL_NEG_THIRD,
                        ds_pcs_pkg::LVL_POS_THIRD, ds_pcs_pkg::LVL_POS_ONE};
  int bad_count = 0;
  int n_tests = 0;

  ds_pcs_symbol_mapper uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce),
    .i_pcs_reset(pcs_reset), .i_rate_sel(rate_sel), .i_train_mode(train_mode),
    .i_train_bit(train_bit), .i_data_valid(data_valid), .i_data(data),
    .o_data_ready(data_ready), .i_pma_ready(pma_ready), .o_sym(sym),
    .o_tx_enable(tx_en), .o_rx_enable(rx_en), .o_rate(rate));
  ds_pma_model pma (.i_mclk(mclk), .i_en(pma_en), .i_slow(pma_slow), .i_sym(sym),
    .o_strobe(pma_ready));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [32:0] nxt(input logic [32:0] s);
    return {s[31:0], ^(s & ds_pcs_pkg::SCR_TAPS)};
  endfunction

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic wait_run(input ds_pcs_pkg::rate_t r);
    repeat (15) @(posedge mclk);
    #1;
    cmp("tx_enable early", 4'h0, {3'h0, tx_en});
    @(posedge mclk);
    #1;
    cmp("tx_enable", 4'h1, {3'h0, tx_en});
    cmp("rx_enable", 4'h1, {3'h0, rx_en});
    cmp("rate", {2'h0, r}, {2'h0, rate});
    scr_q = ds_pcs_pkg::SCR_SEED;
  endtask

  task automatic restart(input ds_pcs_pkg::rate_t r);
    @(posedge mclk);
    rate_sel <= r;
    pcs_reset <= 1'b1;
    @(posedge mclk);
    pcs_reset <= 1'b0;
    wait_run(r);
  endtask

  // Fills, then drains with the select moved in mid-run
  task automatic run_data(input logic [1:0] w[$], input logic slow, input ds_pcs_pkg::rate_t r);
    logic [2:0] e;
    @(posedge mclk);
    foreach (w[i]) begin
      data <= w[i];
      data_valid <= 1'b1;
      @(posedge mclk);
    end
    data_valid <= 1'b0;
    rate_sel <= (r == ds_pcs_pkg::RATE_10G) ? ds_pcs_pkg::RATE_2G5 : ds_pcs_pkg::RATE_10G;
    #1;
    cmp("data_ready", {3'h0, w.size() < 16}, {3'h0, data_ready});
    pma_slow <= slow;
    pma_en <= 1'b1;
    for (int k = 0; k < 200 && pma.got.size() < w.size(); k++) @(posedge mclk);
    pma_en <= 1'b0;
    repeat (4) @(posedge mclk);
    cmp("symbol count", w.size(), pma.got.size());
    cmp("rate held", {2'h0, r}, {2'h0, rate});
    foreach (w[i]) begin
      if (r == ds_pcs_pkg::RATE_10G) begin
        e = l4[w[i] ^ scr_q[1:0]];
        cmp("pam4 level", {1'b0, e}, {1'b0, pma.got.pop_front()});
      end else begin
        e = (w[i][0] ^ scr_q[0]) ? ds_pcs_pkg::LVL_NEG_ONE : ds_pcs_pkg::LVL_POS_ONE;
        cmp("pam2 level", {1'b0, e}, {1'b0, pma.got.pop_front()});
      end
      scr_q = nxt(scr_q);
    end
  endtask

  task automatic run_train;
    for (int b = 0; b < 2; b++) begin
      @(posedge mclk);
      train_mode <= 1'b1;
      train_bit <= b[0];
      pma_en <= 1'b1;
      repeat (4) @(posedge mclk);
      pma_en <= 1'b0;
      repeat (4) @(posedge mclk);
      cmp("train count", 4'h4, pma.got.size());
      while (pma.got.size() > 0) begin
        cmp("train level", {1'b0, b[0] ? ds_pcs_pkg::LVL_NEG_ONE : ds_pcs_pkg::LVL_POS_ONE},
            {1'b0, pma.got.pop_front()});
      end
    end
    train_mode <= 1'b0;
  endtask

  // Enable low must freeze the run phase, even against a soft reset
  task automatic run_freeze;
    @(posedge mclk);
    ce <= 1'b0;
    pcs_reset <= 1'b1;
    repeat (3) @(posedge mclk);
    pcs_reset <= 1'b0;
    @(posedge mclk);
    ce <= 1'b1;
    #1;
    cmp("frozen tx_enable", 1, tx_en);
    cmp("frozen rate", {2'h0, ds_pcs_pkg::RATE_2G5}, {2'h0, rate});
  endtask

  // ----------------------------------------
  // Clock, sequence, watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    {rst_n, pcs_reset, train_mode, train_bit, data_valid, pma_en, pma_slow} = 7'h00;
    data = 2'h0;
    ce = 1'b1;
    rate_sel = ds_pcs_pkg::RATE_10G;
    repeat (12) @(posedge mclk);
    cmp("reset symbol", 4'h0, sym);
    rst_n <= 1'b1;
    wait_run(ds_pcs_pkg::RATE_10G);
    run_data('{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0}, 1'b0, ds_pcs_pkg::RATE_10G);
    run_train();
    run_data('{2'h3, 2'h0, 2'h2, 2'h1}, 1'b1, ds_pcs_pkg::RATE_10G);
    restart(ds_pcs_pkg::RATE_5G);
    run_data('{16{2'h2}}, 1'b0, ds_pcs_pkg::RATE_5G);
    restart(ds_pcs_pkg::RATE_2G5);
    run_data('{2'h1, 2'h3, 2'h0, 2'h2, 2'h1}, 1'b1, ds_pcs_pkg::RATE_2G5);
    run_freeze();
    print_verdict();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end
endmodule
